// [rhpbs_consts.vh]
`ifndef RHPBS_CONSTS_VH
`define RHPBS_CONSTS_VH

`define RHPBS_OFF_FLAGS    4'h0
`define RHPBS_OFF_CENTURY  4'h1
`define RHPBS_OFF_ALM_SEC  4'h2
`define RHPBS_OFF_ALM_MIN  4'h3
`define RHPBS_OFF_ALM_HOUR 4'h4
`define RHPBS_OFF_ALM_DATE 4'h5
`define RHPBS_OFF_ALM_MON  4'h6
`define RHPBS_OFF_WDOG     4'h7
`define RHPBS_OFF_CTRL     4'h8
`define RHPBS_OFF_SEC      4'h9
`define RHPBS_OFF_MIN      4'hA
`define RHPBS_OFF_HOUR     4'hB
`define RHPBS_OFF_DAY      4'hC
`define RHPBS_OFF_DATE     4'hD
`define RHPBS_OFF_MONTH    4'hE
`define RHPBS_OFF_YEAR     4'hF

`define RHPBS_CTRL_WRITE_BIT  7
`define RHPBS_CTRL_READ_BIT   6
`define RHPBS_WDOG_ROUTE_BIT  7
`define RHPBS_ALM_IRQ_EN_BIT  7
`define RHPBS_FLAG_WDOG_BIT   7
`define RHPBS_FLAG_ALARM_BIT  6
`define RHPBS_FLAG_BATLOW_BIT 4

`define RHPBS_RST_CENTURY 8'h20
`define RHPBS_RST_SEC     8'h00
`define RHPBS_RST_MIN     8'h00
`define RHPBS_RST_HOUR    8'h00
`define RHPBS_RST_DAY     8'h01
`define RHPBS_RST_DATE    8'h01
`define RHPBS_RST_MONTH   8'h01
`define RHPBS_RST_YEAR    8'h00

`define RHPBS_CLK_HZ      100000000
`define RHPBS_PWRUP_MS    200
`define RHPBS_PWRUP_CYC   (`RHPBS_PWRUP_MS * (`RHPBS_CLK_HZ / 1000))
`define RHPBS_SEC_CYC     (`RHPBS_CLK_HZ)
`define RHPBS_SIXT_CYC    (`RHPBS_CLK_HZ / 16)
`define RHPBS_WRST_MS     50
`define RHPBS_WRST_CYC    (`RHPBS_WRST_MS * (`RHPBS_CLK_HZ / 1000))

`endif

// [rhpbs_calendar.v]
`timescale 1ns/10ps
`default_nettype none
`include "rhpbs_consts.vh"

module rhpbs_calendar (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       tick,
  input  wire       load,
  input  wire [7:0] ld_sec,
  input  wire [7:0] ld_min,
  input  wire [7:0] ld_hour,
  input  wire [7:0] ld_day,
  input  wire [7:0] ld_date,
  input  wire [7:0] ld_month,
  input  wire [7:0] ld_year,
  input  wire [7:0] ld_cent,
  output reg  [7:0] sec_q,
  output reg  [7:0] min_q,
  output reg  [7:0] hour_q,
  output reg  [7:0] day_q,
  output reg  [7:0] date_q,
  output reg  [7:0] month_q,
  output reg  [7:0] year_q,
  output reg  [7:0] cent_q
);

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // divisible-by-four test on a bcd year; 2100 is not caught
  function leap;
    input [7:0] y;
    begin
      if (y[4])
        leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
        leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function [7:0] last_date;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02:   last_date = leap(y) ? 8'h29 : 8'h28;
        8'h04,
        8'h06,
        8'h09,
        8'h11:   last_date = 8'h30;
        default: last_date = 8'h31;
      endcase
    end
  endfunction

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_q   <= `RHPBS_RST_SEC;
      min_q   <= `RHPBS_RST_MIN;
      hour_q  <= `RHPBS_RST_HOUR;
      day_q   <= `RHPBS_RST_DAY;
      date_q  <= `RHPBS_RST_DATE;
      month_q <= `RHPBS_RST_MONTH;
      year_q  <= `RHPBS_RST_YEAR;
      cent_q  <= `RHPBS_RST_CENTURY;
    end
    else if (load)
    begin
      sec_q   <= ld_sec;
      min_q   <= ld_min;
      hour_q  <= ld_hour;
      day_q   <= ld_day;
      date_q  <= ld_date;
      month_q <= ld_month;
      year_q  <= ld_year;
      cent_q  <= ld_cent;
    end
    else if (tick)
    begin
      sec_q <= (sec_q == 8'h59) ? 8'h00 : bcd_inc(sec_q);
      if (sec_q == 8'h59)
      begin
        min_q <= (min_q == 8'h59) ? 8'h00 : bcd_inc(min_q);
        if (min_q == 8'h59)
        begin
          hour_q <= (hour_q == 8'h23) ? 8'h00 : bcd_inc(hour_q);
          if (hour_q == 8'h23)
          begin
            day_q <= (day_q == 8'h07) ? 8'h01 : bcd_inc(day_q);
            if (date_q == last_date(month_q, year_q))
            begin
              date_q  <= 8'h01;
              month_q <= (month_q == 8'h12) ? 8'h01 : bcd_inc(month_q);
              if (month_q == 8'h12)
              begin
                year_q <= (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
                if (year_q == 8'h99)
                  cent_q <= bcd_inc(cent_q);
              end
            end
            else
              date_q <= bcd_inc(date_q);
          end
        end
      end
    end
  end

endmodule // rhpbs_calendar
`default_nettype wire

// [rhpbs_host_port.v]
`timescale 1ns/10ps
`default_nettype none
`include "rhpbs_consts.vh"

module rhpbs_host_port #(
  parameter [31:0] SEC_CYCLES  = `RHPBS_SEC_CYC,
  parameter [31:0] SIXT_CYCLES = `RHPBS_SIXT_CYC,
  parameter [31:0] PWRUP_CYCLES = `RHPBS_PWRUP_CYC,
  parameter [31:0] WRST_CYCLES = `RHPBS_WRST_CYC
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire [3:0] register_address,
  input  wire [7:0] data_lines_in,
  output reg  [7:0] data_lines_out,
  output wire       data_lines_oe_n,
  input  wire       chip_enable_n,
  input  wire       output_enable_n,
  input  wire       write_enable_n,
  input  wire       external_ram_select_n,
  input  wire       bank_select,
  output wire       ram_enable_one_n,
  output wire       ram_enable_two_n,
  input  wire       powerfail_deselect_level,
  input  wire       battery_switch_level,
  input  wire       battery_low,
  input  wire       watchdog_kick,
  output wire       reset_out,
  output wire       reset_out_oe_n,
  output wire       irq_out,
  output wire       irq_out_oe_n
);

  // monitor conditions: 1 = supply out of tolerance / on battery
  wire pf   = powerfail_deselect_level;
  wire batt = battery_switch_level;
  wire deselect = pf | batt;

  reg  [7:0] mem [0:15];
  integer    i;

  // strobe synchronisers
  reg ce_m_q;
  reg ce_s_q;
  reg we_m_q;
  reg we_s_q;
  reg wr_act_q;
  reg rd_act_q;
  reg [3:0] wa_q;
  reg [7:0] wd_q;
  reg [3:0] ra_q;

  wire wr_act = ~ce_s_q & ~we_s_q;
  wire rd_act = ~ce_s_q & we_s_q;
  wire wr_commit = wr_act_q & ~wr_act & ~deselect;
  wire rd_end    = rd_act_q & ~rd_act & ~deselect;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ce_m_q   <= 1'b1;
      ce_s_q   <= 1'b1;
      we_m_q   <= 1'b1;
      we_s_q   <= 1'b1;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wa_q     <= 4'h0;
      wd_q     <= 8'h00;
      ra_q     <= 4'h0;
    end
    else
    begin
      ce_m_q <= chip_enable_n;
      ce_s_q <= ce_m_q;
      we_m_q <= write_enable_n;
      we_s_q <= we_m_q;
      // a supply dip mid-cycle aborts the write rather than commit junk
      wr_act_q <= wr_act & ~deselect;
      rd_act_q <= rd_act & ~deselect;
      // capture on the raw strobes: data hold after the strobe is zero
      if (!chip_enable_n && !write_enable_n && !deselect)
      begin
        wa_q <= register_address;
        wd_q <= data_lines_in;
      end
      if (!chip_enable_n && write_enable_n && !deselect)
        ra_q <= register_address;
    end
  end

  // one second and one sixteenth second enables
  reg [31:0] sec_div_q;
  reg [31:0] sixt_div_q;
  reg        sec_tick_q;
  reg        sixt_tick_q;
  reg        copy_q;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_div_q   <= 32'h0000_0000;
      sixt_div_q  <= 32'h0000_0000;
      sec_tick_q  <= 1'b0;
      sixt_tick_q <= 1'b0;
      copy_q      <= 1'b0;
    end
    else
    begin
      // keeps counting on battery so time is not lost
      sec_tick_q  <= (sec_div_q == SEC_CYCLES - 32'h1);
      sec_div_q   <= (sec_div_q == SEC_CYCLES - 32'h1) ? 32'h0 : sec_div_q + 32'h1;
      sixt_tick_q <= (sixt_div_q == SIXT_CYCLES - 32'h1);
      sixt_div_q  <= (sixt_div_q == SIXT_CYCLES - 32'h1) ? 32'h0 : sixt_div_q + 32'h1;
      copy_q      <= sec_tick_q;
    end
  end

  // calendar counters
  reg        cal_load_q;
  wire [7:0] c_sec;
  wire [7:0] c_min;
  wire [7:0] c_hour;
  wire [7:0] c_day;
  wire [7:0] c_date;
  wire [7:0] c_month;
  wire [7:0] c_year;
  wire [7:0] c_cent;

  rhpbs_calendar i_rhpbs_calendar (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .tick     (sec_tick_q),
    .load     (cal_load_q),
    .ld_sec   (mem[`RHPBS_OFF_SEC]),
    .ld_min   (mem[`RHPBS_OFF_MIN]),
    .ld_hour  (mem[`RHPBS_OFF_HOUR]),
    .ld_day   (mem[`RHPBS_OFF_DAY]),
    .ld_date  (mem[`RHPBS_OFF_DATE]),
    .ld_month (mem[`RHPBS_OFF_MONTH]),
    .ld_year  (mem[`RHPBS_OFF_YEAR]),
    .ld_cent  (mem[`RHPBS_OFF_CENTURY]),
    .sec_q    (c_sec),
    .min_q    (c_min),
    .hour_q   (c_hour),
    .day_q    (c_day),
    .date_q   (c_date),
    .month_q  (c_month),
    .year_q   (c_year),
    .cent_q   (c_cent)
  );

  wire [7:0] ctrl = mem[`RHPBS_OFF_CTRL];
  wire freeze = ctrl[`RHPBS_CTRL_WRITE_BIT] | ctrl[`RHPBS_CTRL_READ_BIT];
  wire ctrl_wr = wr_commit && (wa_q == `RHPBS_OFF_CTRL);

  // user copies and settings
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < 16; i = i + 1)
        mem[i] <= 8'h00;
      mem[`RHPBS_OFF_CENTURY] <= `RHPBS_RST_CENTURY;
      mem[`RHPBS_OFF_DAY]     <= `RHPBS_RST_DAY;
      mem[`RHPBS_OFF_DATE]    <= `RHPBS_RST_DATE;
      mem[`RHPBS_OFF_MONTH]   <= `RHPBS_RST_MONTH;
      cal_load_q <= 1'b0;
    end
    else
    begin
      // leaving write-freeze pushes the copies into the counters
      cal_load_q <= ctrl_wr & ctrl[`RHPBS_CTRL_WRITE_BIT] & ~wd_q[`RHPBS_CTRL_WRITE_BIT];
      // a refresh in the load cycle would write the stale count back
      if (copy_q && !freeze && !cal_load_q)
      begin
        mem[`RHPBS_OFF_SEC]     <= c_sec;
        mem[`RHPBS_OFF_MIN]     <= c_min;
        mem[`RHPBS_OFF_HOUR]    <= c_hour;
        mem[`RHPBS_OFF_DAY]     <= c_day;
        mem[`RHPBS_OFF_DATE]    <= c_date;
        mem[`RHPBS_OFF_MONTH]   <= c_month;
        mem[`RHPBS_OFF_YEAR]    <= c_year;
        mem[`RHPBS_OFF_CENTURY] <= c_cent;
      end
      // flag byte lives in its own flops; host data wins over the refresh
      if (wr_commit && (wa_q != `RHPBS_OFF_FLAGS))
        mem[wa_q] <= wd_q;
    end
  end

  // watchdog
  reg  [10:0] wd_cnt_q;
  reg         wd_to_q;
  reg         wdi_q;
  wire [7:0]  watchdog_route_bit = mem[`RHPBS_OFF_WDOG];
  wire [10:0] wd_limit = {6'h00, watchdog_route_bit[6:2]} << {watchdog_route_bit[1:0], 1'b0};
  wire        wd_kick = (watchdog_kick ^ wdi_q) | (wr_commit && (wa_q == `RHPBS_OFF_WDOG));
  wire        wd_on = (watchdog_route_bit[6:2] != 5'h00);

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_cnt_q <= 11'h000;
      wd_to_q  <= 1'b0;
      wdi_q    <= 1'b0;
    end
    else
    begin
      wdi_q   <= watchdog_kick;
      wd_to_q <= 1'b0;
      if (!wd_on || wd_kick)
        wd_cnt_q <= wd_limit;
      else if (sixt_tick_q)
      begin
        if (wd_cnt_q <= 11'h001)
        begin
          wd_to_q  <= 1'b1;
          wd_cnt_q <= wd_limit;
        end
        else
          wd_cnt_q <= wd_cnt_q - 11'h001;
      end
    end
  end

  // alarm compare against the counters, once per copy_q pulse, even under freeze
  wire [7:0] am = mem[`RHPBS_OFF_ALM_MON];
  wire alarm_hit = copy_q &&
                   (am[4:0] == c_month[4:0]) &&
                   (mem[`RHPBS_OFF_ALM_DATE][5:0] == c_date[5:0]) &&
                   (mem[`RHPBS_OFF_ALM_HOUR][5:0] == c_hour[5:0]) &&
                   (mem[`RHPBS_OFF_ALM_MIN][6:0] == c_min[6:0]) &&
                   (mem[`RHPBS_OFF_ALM_SEC][6:0] == c_sec[6:0]);

  // flags and reset pulse
  reg        wflag_q;
  reg        aflag_q;
  reg [31:0] wrst_cnt_q;
  reg [31:0] hold_cnt_q;
  wire       flag_rd = rd_end && (ra_q == `RHPBS_OFF_FLAGS);
  wire [7:0] flags = {wflag_q, aflag_q, 1'b0, battery_low, 4'h0};

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wflag_q    <= 1'b0;
      aflag_q    <= 1'b0;
      wrst_cnt_q <= 32'h0000_0000;
      hold_cnt_q <= PWRUP_CYCLES;
    end
    else
    begin
      // a new event in the read-clear cycle survives
      if (wd_to_q)
        wflag_q <= 1'b1;
      else if (flag_rd)
        wflag_q <= 1'b0;
      if (alarm_hit)
        aflag_q <= 1'b1;
      else if (flag_rd)
        aflag_q <= 1'b0;
      if (wd_to_q && watchdog_route_bit[`RHPBS_WDOG_ROUTE_BIT])
        wrst_cnt_q <= WRST_CYCLES;
      else if (wrst_cnt_q != 32'h0)
        wrst_cnt_q <= wrst_cnt_q - 32'h1;
      if (deselect)
        hold_cnt_q <= PWRUP_CYCLES;
      else if (hold_cnt_q != 32'h0)
        hold_cnt_q <= hold_cnt_q - 32'h1;
    end
  end

  wire hold = (hold_cnt_q != 32'h0);

  // read data
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      data_lines_out <= 8'h00;
    else if (register_address == `RHPBS_OFF_FLAGS)
      data_lines_out <= flags;
    else
      data_lines_out <= mem[register_address];
  end

  // bus drive follows the pins directly, as an async part would
  assign data_lines_oe_n = ~(~chip_enable_n & write_enable_n & ~output_enable_n
                             & ~deselect);

  // ram enables; bank_select picks one, so both enables are never low together
  wire ram_off = deselect | hold | external_ram_select_n;
  assign ram_enable_one_n = ram_off | bank_select;
  assign ram_enable_two_n = ram_off | ~bank_select;

  // open-drain outputs; released on battery like the data bus, while the ram enables are driven high
  wire rst_active = pf | hold | (wrst_cnt_q != 32'h0);
  wire irq_active = (aflag_q & am[`RHPBS_ALM_IRQ_EN_BIT]) |
                    (wflag_q & ~watchdog_route_bit[`RHPBS_WDOG_ROUTE_BIT]);
  assign reset_out      = 1'b0;
  assign reset_out_oe_n = ~rst_active | batt;
  assign irq_out        = 1'b0;
  assign irq_out_oe_n   = ~irq_active | batt;

endmodule // rhpbs_host_port
`default_nettype wire

// [rhpbs_placeholder_none.v]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [rhpbs_host_port_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module rhpbs_host_port_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic external_ram_select_n,
  input wire logic bank_select,
  input wire logic powerfail_deselect_level,
  input wire logic battery_switch_level,
  input wire logic data_lines_oe_n,
  input wire logic ram_enable_one_n,
  input wire logic ram_enable_two_n,
  input wire logic reset_out_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ce_high_hiz: assert property (chip_enable_n |-> data_lines_oe_n)
    else $error("data bus driven with chip enable high");
  a_write_no_drive: assert property (!chip_enable_n && !write_enable_n |-> data_lines_oe_n)
    else $error("data bus driven during write");
  a_read_drives: assert property (!chip_enable_n && write_enable_n && !output_enable_n
      && !powerfail_deselect_level && !battery_switch_level |-> !data_lines_oe_n)
    else $error("read cycle not driving data bus");
  a_deselect_hiz: assert property (powerfail_deselect_level || battery_switch_level
      |-> data_lines_oe_n)
    else $error("data bus driven during deselect");
  a_deselect_ram_off: assert property (powerfail_deselect_level || battery_switch_level
      |-> ram_enable_one_n && ram_enable_two_n)
    else $error("ram enable active during deselect");
  a_bank_one_cause: assert property (!ram_enable_one_n |-> !external_ram_select_n && !bank_select)
    else $error("ram enable one low without its cause");
  a_bank_two_cause: assert property (!ram_enable_two_n |-> !external_ram_select_n && bank_select)
    else $error("ram enable two low without its cause");
  a_ext_high_off: assert property (external_ram_select_n |-> ram_enable_one_n && ram_enable_two_n)
    else $error("ram enable active with external select high");
  a_hold_after_fail: assert property ($fell(powerfail_deselect_level)
      |-> (ram_enable_one_n && ram_enable_two_n) [*8])
    else $error("ram enable released too early after supply return");
  a_reset_in_hold: assert property ($fell(powerfail_deselect_level) && !battery_switch_level
      |-> (!reset_out_oe_n) [*8])
    else $error("reset output released too early after supply return");
endmodule // rhpbs_host_port_sva

bind rhpbs_host_port rhpbs_host_port_sva i_rhpbs_host_port_sva (
  .sys_clk                  (sys_clk),
  .resetn                   (resetn),
  .chip_enable_n            (chip_enable_n),
  .output_enable_n          (output_enable_n),
  .write_enable_n           (write_enable_n),
  .external_ram_select_n    (external_ram_select_n),
  .bank_select              (bank_select),
  .powerfail_deselect_level (powerfail_deselect_level),
  .battery_switch_level     (battery_switch_level),
  .data_lines_oe_n          (data_lines_oe_n),
  .ram_enable_one_n         (ram_enable_one_n),
  .ram_enable_two_n         (ram_enable_two_n),
  .reset_out_oe_n           (reset_out_oe_n)
);
`default_nettype wire

// [rhpbs_sram_model.sv]
`timescale 1ns/10ps
`default_nettype none
// no data path reaches the srams here; the model reports which bank answers
module rhpbs_sram_model (
  input  wire logic       ram_enable_one_n,
  input  wire logic       ram_enable_two_n,
  output var  logic [1:0] bank_active
);
  always_comb
  begin
    bank_active = {~ram_enable_two_n, ~ram_enable_one_n};
  end
endmodule // rhpbs_sram_model
`default_nettype wire

// [tb_rhpbs_host_port.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_rhpbs_host_port;
  logic       sys_clk;
  logic       resetn;
  logic [3:0] register_address;
  logic [7:0] data_lines_in;
  logic [7:0] data_lines_out;
  logic       data_lines_oe_n;
  logic       chip_enable_n;
  logic       output_enable_n;
  logic       write_enable_n;
  logic       external_ram_select_n;
  logic       bank_select;
  logic       ram_enable_one_n;
  logic       ram_enable_two_n;
  logic       powerfail_deselect_level;
  logic       battery_switch_level;
  logic       battery_low;
  logic       watchdog_kick;
  logic       reset_out_oe_n;
  logic       irq_out_oe_n;
  logic [1:0] bank_active;
  int         err_count;
  int         num_checks;
  logic [3:0] reg_addr [3] = '{4'h1, 4'h7, 4'h8};
  logic [7:0] reg_val  [3] = '{8'h19, 8'h80, 8'h3F};
  logic [1:0] bank_exp [4] = '{2'b01, 2'b10, 2'b00, 2'b00};

  rhpbs_host_port #(.SEC_CYCLES(20), .SIXT_CYCLES(4), .PWRUP_CYCLES(16), .WRST_CYCLES(8))
  i_rhpbs_host_port (
    .sys_clk(sys_clk), .resetn(resetn), .register_address(register_address),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .external_ram_select_n(external_ram_select_n), .bank_select(bank_select),
    .ram_enable_one_n(ram_enable_one_n), .ram_enable_two_n(ram_enable_two_n),
    .powerfail_deselect_level(powerfail_deselect_level),
    .battery_switch_level(battery_switch_level), .battery_low(battery_low),
    .watchdog_kick(watchdog_kick), .reset_out(), .reset_out_oe_n(reset_out_oe_n),
    .irq_out(), .irq_out_oe_n(irq_out_oe_n)
  );

  rhpbs_sram_model i_rhpbs_sram_model (
    .ram_enable_one_n(ram_enable_one_n), .ram_enable_two_n(ram_enable_two_n),
    .bank_active(bank_active)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // bounded wait for an open-drain pin to be pulled low
  task automatic wait_pin(input logic rst_pin, input string what);
    int n;
    n = 0;
    while (((rst_pin ? reset_out_oe_n : irq_out_oe_n) !== 1'b0) && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk8({7'h00, rst_pin ? reset_out_oe_n : irq_out_oe_n}, 8'h00, what);
  endtask

  // output enable held low on purpose: writes must win regardless of it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    external_ram_select_n = 1'b1;
    register_address = a;
    data_lines_in = d;
    output_enable_n = 1'b0;
    chip_enable_n = 1'b0;
    write_enable_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk8({7'h00, data_lines_oe_n}, 8'h01, "bus state in write");
    chip_enable_n = 1'b1;
    write_enable_n = 1'b1;
    output_enable_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic hiz);
    @(negedge sys_clk);
    external_ram_select_n = 1'b1;
    register_address = a;
    chip_enable_n = 1'b0;
    output_enable_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk8({7'h00, data_lines_oe_n}, {7'h00, hiz}, "bus state in read");
    if (!hiz)
      chk8(data_lines_out, exp, "read data");
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    $display("unexpected at %0t: run did not complete", $time);
    tally_and_finish;
  end

  initial
  begin
    err_count = 0;
    num_checks = 0;
    resetn = 1'b0;
    register_address = 4'h0;
    data_lines_in = 8'h00;
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    write_enable_n = 1'b1;
    external_ram_select_n = 1'b1;
    bank_select = 1'b0;
    powerfail_deselect_level = 1'b0;
    battery_switch_level = 1'b0;
    battery_low = 1'b0;
    watchdog_kick = 1'b0;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk8({6'h00, reset_out_oe_n, irq_out_oe_n}, 8'h01, "pins in power-up hold");
    repeat (16) @(negedge sys_clk);
    chk8({6'h00, reset_out_oe_n, irq_out_oe_n}, 8'h03, "pins after hold");
    rd(4'h1, 8'h20, 1'b0);
    rd(4'h0, 8'h00, 1'b0);
    // copies only stick under write-freeze; the final 8h write loads the counters
    wr(4'h8, 8'h80);
    for (int i = 0; i < 3; i++)
      wr(reg_addr[i], reg_val[i]);
    for (int i = 0; i < 3; i++)
      rd(reg_addr[i], reg_val[i], 1'b0);
    wr(4'h7, 8'h04);
    wait_pin(1'b0, "interrupt on watchdog timeout");
    rd(4'h0, 8'h80, 1'b0);
    wr(4'h7, 8'h84);
    wait_pin(1'b1, "reset on watchdog timeout");
    wr(4'h7, 8'h00);
    rd(4'h0, 8'h80, 1'b0);
    repeat (12) @(negedge sys_clk);
    chk8({6'h00, reset_out_oe_n, irq_out_oe_n}, 8'h03, "pins after watchdog stop");
    wr(4'h0, 8'hFF);
    battery_low = 1'b1;
    rd(4'h0, 8'h10, 1'b0);
    battery_low = 1'b0;
    @(negedge sys_clk);
    chip_enable_n = 1'b0;
    @(negedge sys_clk);
    chk8({7'h00, data_lines_oe_n}, 8'h01, "bus state with output enable high");
    chip_enable_n = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      powerfail_deselect_level = (k == 0);
      battery_switch_level = (k == 1);
      rd(4'h1, 8'h00, 1'b1);
      wr(4'h1, 8'hA5);
      external_ram_select_n = 1'b0;
      @(negedge sys_clk);
      chk8({6'h00, bank_active}, 8'h00, "ram bank during deselect");
      powerfail_deselect_level = 1'b0;
      battery_switch_level = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk8({6'h00, bank_active}, 8'h00, "ram bank in power-up hold");
      repeat (10) @(negedge sys_clk);
      chk8({6'h00, bank_active}, 8'h01, "ram bank after hold");
      rd(4'h1, 8'h19, 1'b0);
    end
    for (int j = 0; j < 4; j++)
    begin
      @(negedge sys_clk);
      external_ram_select_n = j[1];
      bank_select = j[0];
      @(negedge sys_clk);
      chk8({6'h00, bank_active}, {6'h00, bank_exp[j]}, "ram bank select");
    end
    tally_and_finish;
  end
endmodule // tb_rhpbs_host_port
`default_nettype wire
